// file: move_arith_consts.vh
// constants for the move and arithmetic datapath
`ifndef MOVE_ARITH_CONSTS_VH
`define MOVE_ARITH_CONSTS_VH

// register byte offsets
`define REG_CMD          12'h000
`define REG_ACC          12'h004
`define REG_FLAGS        12'h008
`define REG_SP           12'h00C
`define REG_STATUS       12'h010
// data memory window
`define MEM_WIN_SEL      3'b010

// flag byte bit positions
`define FLAG_Z           0
`define FLAG_C           1
`define FLAG_AC          2
`define FLAG_OV          3

// status bit positions
`define STAT_BUSY        0
`define STAT_RANGE       1
`define STAT_DROP        2

// reset values
`define ACC_RST          8'h00
`define FLAGS_RST        4'h0
`define SP_RST           8'h00
`define CMD_RST          32'h0000_0000

// command word fields
`define CMD_OP_HI        4
`define CMD_MADDR_LO     8
`define CMD_IMM_LO       16
`define CMD_BIT_LO       24

// highest address reachable by bit forms
`define BIT_ADDR_MAX     8'h3F
// stack step per save
`define SP_STEP          8'h02

// command codes
`define OP_NOP           5'h00
`define OP_MOV_A_I       5'h01
`define OP_MOV_M_A       5'h02
`define OP_MOV_A_M       5'h03
`define OP_MOV_A_IO      5'h04
`define OP_MOV_IO_A      5'h05
`define OP_TMR_TO_WORD   5'h06
`define OP_WORD_TO_TMR   5'h07
`define OP_IDX_RD        5'h08
`define OP_IDX_WR        5'h09
`define OP_XCH           5'h0A
`define OP_SAVE_AF       5'h0B
`define OP_RESTORE_AF    5'h0C
`define OP_ADD_A_I       5'h0D
`define OP_ADD_A_M       5'h0E
`define OP_ADD_M_A       5'h0F
`define OP_ADDC_A_M      5'h10
`define OP_ADDC_M_A      5'h11
`define OP_ADDC_A        5'h12
`define OP_ADDC_M        5'h13
`define OP_SUB_A_I       5'h14
`define OP_SUB_A_M       5'h15
`define OP_SUB_M_A       5'h16
`define OP_SUBC_A_M      5'h17
`define OP_SUBC_M_A      5'h18
`define OP_SUBC_A        5'h19
`define OP_SUBC_M        5'h1A
`define OP_INC_M         5'h1B
`define OP_DEC_M         5'h1C
`define OP_CLR_M         5'h1D
`define OP_BIT_CLR_M     5'h1E
`define OP_BIT_SET_M     5'h1F

`endif

// file: alu_core.v
// adder/subtractor with zero, carry, nibble carry and signed range flags
`timescale 1ns/10ps
`default_nettype none
module alu_core #(
    parameter W = 8
) (
    // operands
    input  wire [W-1:0] opA,
    input  wire [W-1:0] opB,
    input  wire         subtract,
    input  wire         carryIn,
    // result and flags
    output wire [W-1:0] result,
    output wire         zeroOut,
    output wire         carryOut,
    output wire         nibbleOut,
    output wire         rangeOut
);
    // subtraction adds the two's complement; carry in acts as borrow
    wire [W-1:0] bEff = subtract ? ~opB : opB;
    wire         cEff = subtract ? ~carryIn : carryIn;
    wire [W:0]   full = {1'b0, opA} + {1'b0, bEff} + {{W{1'b0}}, cEff};
    wire [4:0]   low  = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};

    assign result    = full[W-1:0];
    assign zeroOut   = (full[W-1:0] == {W{1'b0}});
    assign carryOut  = full[W] ^ subtract;
    assign nibbleOut = low[4] ^ subtract;
    assign rangeOut  = (opA[W-1] == bEff[W-1]) & (full[W-1] != opA[W-1]);
endmodule // alu_core
`default_nettype wire

// file: move_arith_datapath.v
// move and arithmetic execution datapath with an ahb-lite register slave
// What this block does
// - zero flag set on zero result
// - nibble carry flag on low nibble carry
// - carry flag on add carry or borrow
// - signed range flag on two's complement overflow
// - bit forms only on addresses 0..0x3F
// - load from memory or io sets zero only
// - immediate load and stores keep all flags
// - timer count copied to memory word, no flags
// - memory word loads timer, low then high
// - indirect read takes two cycles, no flags
// - indirect write takes two cycles, no flags
// - exchange accumulator with memory, no flags
// - save pair at stack pointer, add two
// - restore accumulator and flags from stack pair
// - add immediate or memory, all flags
// - add with carry, memory operand, all flags
// - add carry alone in place, all flags
// - subtract via two's complement, all flags
// - subtract with borrow, two operands, all flags
// - subtract borrow alone in place, all flags
// - memory increment and decrement, all flags
// - memory clear writes zero, flags kept
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "move_arith_consts.vh"
module move_arith_datapath #(
    parameter MEM_DEPTH = 128,
    parameter ADDR_W    = 7
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // io register space
    output reg  [7:0]  ioAddr,
    output reg  [7:0]  ioWrData,
    output reg         ioWrEn,
    output reg         ioRdEn,
    input  wire [7:0]  ioRdData,
    // sixteen_bit_timer
    input  wire [15:0] timerCount,
    output reg  [15:0] timerLoadVal,
    output reg         timerLoad,
    // status
    output reg         busy
);
    // data memory
    reg  [7:0]        mem [0:MEM_DEPTH-1];

    // architectural state
    reg  [7:0]        acc_r;
    reg  [3:0]        flags_r;
    reg  [7:0]        sp_r;
    reg  [31:0]       cmd_r;
    reg               execGo_r;
    reg               idxStage_r;
    reg               idxWrite_r;
    reg  [7:0]        idxPtr_r;
    reg               rangeErr_r;
    reg               cmdDrop_r;

    reg               wrPend_r;
    reg               rdPend_r;
    reg  [11:0]       bAddr_r;

    // command fields
    wire [4:0]        op    = cmd_r[`CMD_OP_HI:0];
    wire [7:0]        mAddr = cmd_r[`CMD_MADDR_LO+7:`CMD_MADDR_LO];
    wire [7:0]        imm   = cmd_r[`CMD_IMM_LO+7:`CMD_IMM_LO];
    wire [2:0]        bitN  = cmd_r[`CMD_BIT_LO+2:`CMD_BIT_LO];

    wire [ADDR_W-1:0] mA     = mAddr[ADDR_W-1:0];
    wire [ADDR_W-1:0] mA1    = mA + 1'b1;
    wire [7:0]        memRd  = mem[mA];
    wire [7:0]        memRd1 = mem[mA1];
    wire [7:0]        spDec  = sp_r - `SP_STEP;
    wire [ADDR_W-1:0] spA    = sp_r[ADDR_W-1:0];
    wire [ADDR_W-1:0] spA1   = spA + 1'b1;
    wire [ADDR_W-1:0] spdA   = spDec[ADDR_W-1:0];
    wire [ADDR_W-1:0] spdA1  = spdA + 1'b1;
    wire [ADDR_W-1:0] ptrA   = idxPtr_r[ADDR_W-1:0];

    wire              busyNow = execGo_r | idxStage_r;
    wire              carryF  = flags_r[`FLAG_C];

    // bus decode
    wire              addrPhase = hsel & htrans[1] & hready;
    wire              memWin    = (bAddr_r[11:9] == `MEM_WIN_SEL);
    wire [ADDR_W-1:0] winIdx    = bAddr_r[ADDR_W+1:2];
    wire              swWr      = wrPend_r & ~busyNow;
    wire              cmdWr     = wrPend_r & (bAddr_r == `REG_CMD);
    wire              statWr    = wrPend_r & (bAddr_r == `REG_STATUS);

    // alu operand selection
    reg  [7:0]        aluA;
    reg  [7:0]        aluB;
    reg               aluSub;
    reg               aluCin;
    reg               aluUse;
    reg               aluToMem;
    wire [7:0]        aluRes;
    wire              aluZ;
    wire              aluC;
    wire              aluAC;
    wire              aluOV;
    reg  [3:0]        aluFl;

    reg  [7:0]        acc_nxt;
    reg  [3:0]        flags_nxt;
    reg  [7:0]        sp_nxt;
    reg               we0;
    reg  [ADDR_W-1:0] wa0;
    reg  [7:0]        wd0;
    reg               we1;
    reg  [ADDR_W-1:0] wa1;
    reg  [7:0]        wd1;
    reg               ioWr_nxt;
    reg               tLoad_nxt;
    reg               idxStart;
    reg               rangeSet;
    reg  [7:0]        bitMask;
    reg  [31:0]       rdMux;

    alu_core #(
        .W         (8)
    ) u_alu (
        .opA       (aluA),
        .opB       (aluB),
        .subtract  (aluSub),
        .carryIn   (aluCin),
        .result    (aluRes),
        .zeroOut   (aluZ),
        .carryOut  (aluC),
        .nibbleOut (aluAC),
        .rangeOut  (aluOV)
    );

    // execution decode
    always @* begin
        aluA      = acc_r;
        aluB      = 8'h00;
        aluSub    = 1'b0;
        aluCin    = 1'b0;
        aluUse    = 1'b0;
        aluToMem  = 1'b0;
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        sp_nxt    = sp_r;
        we0       = 1'b0;
        wa0       = mA;
        wd0       = acc_r;
        we1       = 1'b0;
        wa1       = mA1;
        wd1       = 8'h00;
        ioWr_nxt  = 1'b0;
        tLoad_nxt = 1'b0;
        idxStart  = 1'b0;
        rangeSet  = 1'b0;
        bitMask   = 8'h01 << bitN;
        aluFl     = {aluOV, aluAC, aluC, aluZ};
        if (idxStage_r) begin
            if (idxWrite_r) begin
                we0 = 1'b1;
                wa0 = ptrA;
            end else begin
                acc_nxt = mem[ptrA];
            end
        end else if (execGo_r) begin
            case (op)
                `OP_MOV_A_I: begin
                    acc_nxt = imm;
                end
                `OP_MOV_M_A: begin
                    we0 = 1'b1;
                end
                `OP_MOV_IO_A: begin
                    ioWr_nxt = 1'b1;
                end
                `OP_MOV_A_M: begin
                    acc_nxt = memRd;
                    flags_nxt[`FLAG_Z] = (memRd == 8'h00);
                end
                `OP_MOV_A_IO: begin
                    acc_nxt = ioRdData;
                    flags_nxt[`FLAG_Z] = (ioRdData == 8'h00);
                end
                `OP_TMR_TO_WORD: begin
                    we0 = 1'b1;
                    wd0 = timerCount[7:0];
                    we1 = 1'b1;
                    wd1 = timerCount[15:8];
                end
                `OP_WORD_TO_TMR: begin
                    tLoad_nxt = 1'b1;
                end
                `OP_IDX_RD, `OP_IDX_WR: begin
                    idxStart = 1'b1;
                end
                `OP_XCH: begin
                    acc_nxt = memRd;
                    we0 = 1'b1;
                end
                `OP_SAVE_AF: begin
                    we0 = 1'b1;
                    wa0 = spA;
                    we1 = 1'b1;
                    wa1 = spA1;
                    wd1 = {4'h0, flags_r};
                    sp_nxt = sp_r + `SP_STEP;
                end
                `OP_RESTORE_AF: begin
                    sp_nxt = spDec;
                    acc_nxt = mem[spdA];
                    flags_nxt = mem[spdA1][3:0];
                end
                `OP_ADD_A_I: begin
                    aluB = imm;
                    aluUse = 1'b1;
                end
                `OP_ADD_A_M, `OP_ADD_M_A: begin
                    aluB = memRd;
                    aluUse = 1'b1;
                    aluToMem = (op == `OP_ADD_M_A);
                end
                `OP_ADDC_A_M, `OP_ADDC_M_A: begin
                    aluB = memRd;
                    aluCin = carryF;
                    aluUse = 1'b1;
                    aluToMem = (op == `OP_ADDC_M_A);
                end
                `OP_ADDC_A, `OP_ADDC_M: begin
                    aluA = (op == `OP_ADDC_M) ? memRd : acc_r;
                    aluCin = carryF;
                    aluUse = 1'b1;
                    aluToMem = (op == `OP_ADDC_M);
                end
                `OP_SUB_A_I, `OP_SUB_A_M: begin
                    aluB = (op == `OP_SUB_A_I) ? imm : memRd;
                    aluSub = 1'b1;
                    aluUse = 1'b1;
                end
                `OP_SUB_M_A: begin
                    aluA = memRd;
                    aluB = acc_r;
                    aluSub = 1'b1;
                    aluUse = 1'b1;
                    aluToMem = 1'b1;
                end
                `OP_SUBC_A_M, `OP_SUBC_M_A: begin
                    aluA = (op == `OP_SUBC_M_A) ? memRd : acc_r;
                    aluB = (op == `OP_SUBC_M_A) ? acc_r : memRd;
                    aluSub = 1'b1;
                    aluCin = carryF;
                    aluUse = 1'b1;
                    aluToMem = (op == `OP_SUBC_M_A);
                end
                `OP_SUBC_A, `OP_SUBC_M: begin
                    aluA = (op == `OP_SUBC_M) ? memRd : acc_r;
                    aluSub = 1'b1;
                    aluCin = carryF;
                    aluUse = 1'b1;
                    aluToMem = (op == `OP_SUBC_M);
                end
                `OP_INC_M, `OP_DEC_M: begin
                    aluA = memRd;
                    aluSub = (op == `OP_DEC_M);
                    aluCin = 1'b1;
                    aluUse = 1'b1;
                    aluToMem = 1'b1;
                end
                `OP_CLR_M: begin
                    we0 = 1'b1;
                    wd0 = 8'h00;
                end
                `OP_BIT_CLR_M, `OP_BIT_SET_M: begin
                    if (mAddr > `BIT_ADDR_MAX) begin
                        rangeSet = 1'b1;
                    end else begin
                        we0 = 1'b1;
                        wd0 = (op == `OP_BIT_SET_M) ? (memRd | bitMask) : (memRd & ~bitMask);
                    end
                end
                default: ;
            endcase
            if (aluUse) begin
                flags_nxt = aluFl;
                if (aluToMem) begin
                    we0 = 1'b1;
                    wd0 = aluRes;
                end else begin
                    acc_nxt = aluRes;
                end
            end
        end else if (swWr & memWin) begin
            we0 = 1'b1;
            wa0 = winIdx;
            wd0 = hwdata[7:0];
        end
    end

    // data memory write ports
    always @(posedge sys_clk) begin
        if (we0) begin
            mem[wa0] <= wd0;
        end
        if (we1) begin
            mem[wa1] <= wd1;
        end
    end

    // read data mux
    always @* begin
        rdMux = 32'h0000_0000;
        case (bAddr_r)
            `REG_CMD:    rdMux = cmd_r;
            `REG_ACC:    rdMux = {24'h00_0000, acc_r};
            `REG_FLAGS:  rdMux = {28'h000_0000, flags_r};
            `REG_SP:     rdMux = {24'h00_0000, sp_r};
            `REG_STATUS: rdMux = {29'h000_0000, cmdDrop_r, rangeErr_r, busyNow};
            default: begin
                if (memWin) begin
                    rdMux = {24'h00_0000, mem[winIdx]};
                end
            end
        endcase
    end

    // bus slave and architectural state
    always @(posedge sys_clk) begin
        if (rst) begin
            hrdata       <= 32'h0000_0000;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            wrPend_r     <= 1'b0;
            rdPend_r     <= 1'b0;
            bAddr_r      <= 12'h000;
            acc_r        <= `ACC_RST;
            flags_r      <= `FLAGS_RST;
            sp_r         <= `SP_RST;
            cmd_r        <= `CMD_RST;
            execGo_r     <= 1'b0;
            idxStage_r   <= 1'b0;
            idxWrite_r   <= 1'b0;
            idxPtr_r     <= 8'h00;
            rangeErr_r   <= 1'b0;
            cmdDrop_r    <= 1'b0;
            ioAddr       <= 8'h00;
            ioWrData     <= 8'h00;
            ioWrEn       <= 1'b0;
            ioRdEn       <= 1'b0;
            timerLoadVal <= 16'h0000;
            timerLoad    <= 1'b0;
            busy         <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rdPend_r) begin
                hrdata    <= rdMux;
                hreadyout <= 1'b1;
                rdPend_r  <= 1'b0;
                wrPend_r  <= 1'b0;
            end else if (addrPhase) begin
                bAddr_r   <= haddr[11:0];
                wrPend_r  <= hwrite;
                rdPend_r  <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wrPend_r  <= 1'b0;
            end
            acc_r      <= acc_nxt;
            flags_r    <= flags_nxt;
            sp_r       <= sp_nxt;
            ioWrEn     <= ioWr_nxt;
            ioWrData   <= acc_r;
            timerLoad  <= tLoad_nxt;
            ioRdEn     <= 1'b0;
            if (tLoad_nxt) begin
                timerLoadVal <= {memRd1, memRd};
            end
            if (swWr & (bAddr_r == `REG_ACC)) begin
                acc_r <= hwdata[7:0];
            end
            if (swWr & (bAddr_r == `REG_FLAGS)) begin
                flags_r <= hwdata[3:0];
            end
            if (swWr & (bAddr_r == `REG_SP)) begin
                sp_r <= hwdata[7:0];
            end
            execGo_r   <= 1'b0;
            idxStage_r <= idxStart;
            if (idxStart) begin
                idxPtr_r   <= memRd;
                idxWrite_r <= (op == `OP_IDX_WR);
            end
            if (cmdWr & ~busyNow) begin
                cmd_r    <= hwdata;
                execGo_r <= 1'b1;
                ioAddr   <= hwdata[`CMD_IMM_LO+7:`CMD_IMM_LO];
                ioRdEn   <= (hwdata[`CMD_OP_HI:0] == `OP_MOV_A_IO);
            end
            busy <= (cmdWr & ~busyNow) | idxStart;
            // sticky errors, a new event beats a clear
            rangeErr_r <= rangeSet | (rangeErr_r & ~(statWr & hwdata[`STAT_RANGE]));
            cmdDrop_r  <= (cmdWr & busyNow) | (cmdDrop_r & ~(statWr & hwdata[`STAT_DROP]));
        end
    end
endmodule // move_arith_datapath
`default_nettype wire

// file: move_arith_props.sv
// port assertions for the move and arithmetic datapath
`timescale 1ns/10ps
`default_nettype none
module move_arith_props (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    // io and timer strobes
    input wire [7:0]  ioAddr,
    input wire        ioWrEn,
    input wire        ioRdEn,
    input wire        timerLoad,
    input wire        busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // command write accepted while idle, ending in its data phase
    sequence cmdPh;
        hsel && htrans[1] && hready && hwrite && haddr[11:0] == 12'h000 ##1 !busy;
    endsequence
    resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
    read_one_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait wrong");
    single_cycle_busy_a: assert property (cmdPh ##0 hwdata[4:0] inside {[5'h01:5'h07],
        [5'h0A:5'h1D]} |=> busy ##1 !busy) else $error("busy not one cycle");
    indirect_two_cycle_a: assert property (cmdPh ##0 hwdata[4:1] == 4'h4 |=>
        busy [*2] ##1 !busy) else $error("indirect not two cycles");
    busy_bounded_a: assert property (busy [*2] |=> !busy) else $error("busy too long");
    io_write_pulse_a: assert property (cmdPh ##0 hwdata[4:0] == 5'h05 |=>
        !ioWrEn ##1 ioWrEn ##1 !ioWrEn) else $error("io write pulse wrong");
    io_read_addr_a: assert property (cmdPh ##0 hwdata[4:0] == 5'h04 |=>
        ioRdEn && ioAddr == $past(hwdata[23:16]) ##1 !ioRdEn) else $error("io read wrong");
    timer_load_pulse_a: assert property (cmdPh ##0 hwdata[4:0] == 5'h07 |=>
        !timerLoad ##1 timerLoad ##1 !timerLoad) else $error("timer load pulse wrong");
endmodule // move_arith_props
bind move_arith_datapath move_arith_props u_props (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ioAddr(ioAddr),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .timerLoad(timerLoad), .busy(busy));
`default_nettype wire

// file: io_timer_model.sv
// io register space and sixteen bit timer at the far side
`timescale 1ns/10ps
`default_nettype none
module io_timer_model (
    // clock
    input wire             sys_clk,
    // io side
    input wire [7:0]       ioAddr,
    input wire [7:0]       ioWrData,
    input wire             ioWrEn,
    input wire             ioRdEn,
    output var logic [7:0] ioRdData,
    // timer side, count held still
    input wire [15:0]      timerLoadVal,
    input wire             timerLoad,
    output var logic [15:0] timerCount
);
    logic [7:0] ioReg [0:255];
    logic [7:0] lastRd_r;
    initial begin
        for (int i = 0; i < 256; i++) ioReg[i] = 8'h00;
        lastRd_r = 8'h00;
        timerCount = 16'h0000;
    end
    always @(posedge sys_clk) begin
        if (ioWrEn) ioReg[ioAddr] <= ioWrData;
        if (ioRdEn) lastRd_r <= ioReg[ioAddr];
        if (timerLoad) timerCount <= timerLoadVal;
    end
    // an unselected read bus shows the inverse of the last byte
    always @* ioRdData = ioRdEn ? ioReg[ioAddr] : ~lastRd_r;
endmodule // io_timer_model
`default_nettype wire

// file: move_arith_datapath_test.sv
// self-checking bench for the move and arithmetic datapath
`timescale 1ns/10ps
`default_nettype none
`include "move_arith_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin numErrors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module move_arith_datapath_test;
    logic        sys_clk, rst, hsel, hwrite;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, ioWrEn, ioRdEn, timerLoad, busy;
    wire  [7:0]  ioAddr, ioWrData, ioRdData;
    wire  [15:0] timerCount, timerLoadVal;
    int          numErrors = 0, compares = 0;
    move_arith_datapath dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
        .ioRdData(ioRdData), .timerCount(timerCount), .timerLoadVal(timerLoadVal),
        .timerLoad(timerLoad), .busy(busy));
    io_timer_model far (.sys_clk(sys_clk), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
        .timerLoadVal(timerLoadVal), .timerLoad(timerLoad), .timerCount(timerCount));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task giveVerdict;
        $display("compares=%0d errors=%0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task waitRdy;
        @(posedge sys_clk);
        for (int n = 0; hreadyout !== 1'b1; n++) begin
            if (n > 20) begin numErrors++; giveVerdict; end
            @(posedge sys_clk);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        htrans <= 2'b10; haddr <= a; hwrite <= 1'b1;
        waitRdy;
        htrans <= 2'b00; hwdata <= d;
        waitRdy;
    endtask
    task rc(input [31:0] a, input [31:0] e);
        htrans <= 2'b10; haddr <= a; hwrite <= 1'b0;
        waitRdy;
        htrans <= 2'b00;
        waitRdy;
        `CHK(hrdata, e);
    endtask
    function [31:0] ma(input [7:0] i);
        ma = 32'h0000_0400 + {22'h0, i, 2'b00};
    endfunction
    task cmd(input [4:0] op, input [7:0] m, input [7:0] imm, input [2:0] bn = 3'h0);
        wr(`REG_CMD, {5'h00, bn, imm, m, 3'h0, op});
        repeat (2) @(posedge sys_clk);
    endtask
    // returns {ov, ac, c, z, result}
    function [11:0] calc(input [7:0] x, input [7:0] y, input ci, input sb);
        logic [8:0] s;
        logic [4:0] n;
        logic       v;
        s = sb ? {1'b0, x} - {1'b0, y} - ci : {1'b0, x} + {1'b0, y} + ci;
        n = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - ci : {1'b0, x[3:0]} + {1'b0, y[3:0]} + ci;
        v = (sb ? (x[7] != y[7]) : (x[7] == y[7])) && (s[7] != x[7]);
        calc = {v, n[4], s[8], s[7:0] == 8'h00, s[7:0]};
    endfunction
    task testMoves;
        wr(`REG_FLAGS, 4'hE);
        wr(ma(5), 8'h00);
        cmd(`OP_MOV_A_I, 8'h00, 8'h80);
        rc(`REG_ACC, 8'h80);
        cmd(`OP_MOV_A_M, 8'h05, 8'h00);
        rc(`REG_FLAGS, 4'hF);
        cmd(`OP_MOV_M_A, 8'h06, 8'h00);
        rc(ma(6), 8'h00);
        wr(ma(5), 8'h81);
        cmd(`OP_MOV_A_M, 8'h05, 8'h00);
        rc(`REG_FLAGS, 4'hE);
        cmd(`OP_MOV_A_I, 8'h00, 8'h5A);
        cmd(`OP_MOV_IO_A, 8'h00, 8'h22);
        cmd(`OP_MOV_A_IO, 8'h00, 8'h22);
        rc(`REG_ACC, 8'h5A);
        cmd(`OP_MOV_A_IO, 8'h00, 8'h23);
        rc(`REG_FLAGS, 4'hF);
        $display("moves done");
    endtask
    task testTimer;
        wr(ma(10), 8'h34);
        wr(ma(11), 8'h12);
        wr(`REG_FLAGS, 4'h5);
        cmd(`OP_WORD_TO_TMR, 8'd10, 8'h00);
        @(posedge sys_clk);
        `CHK(timerCount, 16'h1234);
        cmd(`OP_TMR_TO_WORD, 8'd20, 8'h00);
        rc(ma(20), 8'h34);
        rc(ma(21), 8'h12);
        rc(`REG_FLAGS, 4'h5);
        $display("timer done");
    endtask
    task testIndirect;
        wr(ma(30), 8'h5B);
        wr(ma(31), 8'h00);
        wr(ma(8'h5B), 8'hA5);
        cmd(`OP_IDX_RD, 8'd30, 8'h00);
        rc(`REG_ACC, 8'hA5);
        cmd(`OP_MOV_A_I, 8'h00, 8'h3C);
        cmd(`OP_IDX_WR, 8'd30, 8'h00);
        rc(ma(8'h5B), 8'h3C);
        rc(`REG_FLAGS, 4'h5);
        wr(`REG_CMD, {16'h0000, 8'd30, 3'h0, `OP_IDX_RD});
        wr(`REG_CMD, {8'h00, 8'hEE, 8'h00, 3'h0, `OP_MOV_A_I});
        repeat (2) @(posedge sys_clk);
        rc(`REG_STATUS, 32'h0000_0004);
        rc(`REG_ACC, 8'h3C);
        wr(`REG_STATUS, 32'h0000_0004);
        $display("indirect done");
    endtask
    task testXchStack;
        cmd(`OP_MOV_A_I, 8'h00, 8'h11);
        wr(ma(40), 8'h22);
        cmd(`OP_XCH, 8'd40, 8'h00);
        rc(`REG_ACC, 8'h22);
        rc(ma(40), 8'h11);
        wr(`REG_SP, 8'h50);
        wr(`REG_FLAGS, 4'h9);
        cmd(`OP_MOV_A_I, 8'h00, 8'h77);
        cmd(`OP_SAVE_AF, 8'h00, 8'h00);
        rc(ma(8'h50), 8'h77);
        rc(ma(8'h51), 8'h09);
        rc(`REG_SP, 8'h52);
        wr(`REG_FLAGS, 4'h0);
        cmd(`OP_MOV_A_I, 8'h00, 8'h00);
        cmd(`OP_RESTORE_AF, 8'h00, 8'h00);
        rc(`REG_SP, 8'h50);
        rc(`REG_ACC, 8'h77);
        rc(`REG_FLAGS, 4'h9);
        $display("exchange and stack done");
    endtask
    task testArith;
        logic [7:0]  a, m, x, y;
        logic        c, ci, toMem;
        logic [11:0] e;
        for (int v = 0; v < 3; v++) begin
            for (int i = 13; i <= 28; i++) begin
                a = 8'h0F + v * 8'h71;
                m = 8'h01 + v * 8'h7F;
                c = (i + v) % 2;
                x = a; y = m; ci = 1'b0; toMem = 1'b0;
                case (i)
                    15: toMem = 1'b1;
                    16, 23: ci = c;
                    17: begin ci = c; toMem = 1'b1; end
                    18, 25: begin y = 8'h00; ci = c; end
                    19, 26: begin x = m; y = 8'h00; ci = c; toMem = 1'b1; end
                    22: begin x = m; y = a; toMem = 1'b1; end
                    24: begin x = m; y = a; ci = c; toMem = 1'b1; end
                    27, 28: begin x = m; y = 8'h01; toMem = 1'b1; end
                    default: ;
                endcase
                e = calc(x, y, ci, i >= 20 && i != 27);
                wr(`REG_ACC, a);
                wr(ma(50), m);
                wr(`REG_FLAGS, {c, 1'b0});
                cmd(i[4:0], 8'd50, m);
                rc(toMem ? ma(50) : `REG_ACC, e[7:0]);
                rc(`REG_FLAGS, e[11:8]);
            end
        end
        $display("arithmetic done");
    endtask
    task testClearBits;
        wr(ma(60), 8'h99);
        wr(`REG_FLAGS, 4'hF);
        cmd(`OP_CLR_M, 8'd60, 8'h00);
        rc(ma(60), 8'h00);
        rc(`REG_FLAGS, 4'hF);
        wr(ma(8'h40), 8'h00);
        cmd(`OP_BIT_SET_M, 8'h40, 8'h00, 3'd7);
        rc(ma(8'h40), 8'h00);
        rc(`REG_STATUS, 32'h0000_0002);
        wr(`REG_STATUS, 32'h0000_0002);
        wr(ma(8'h3F), 8'h00);
        cmd(`OP_BIT_SET_M, 8'h3F, 8'h00, 3'd7);
        rc(ma(8'h3F), 8'h80);
        cmd(`OP_BIT_CLR_M, 8'h3F, 8'h00, 3'd7);
        rc(ma(8'h3F), 8'h00);
        rc(`REG_STATUS, 32'h0000_0000);
        rc(32'h0000_0020, 32'h0000_0000);
        $display("clear and bit forms done");
    endtask
    initial begin
        rst = 1'b1; hsel = 1'b1; haddr = 32'h0000_0000; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        testMoves;
        testTimer;
        testIndirect;
        testXchStack;
        testArith;
        testClearBits;
        giveVerdict;
    end
endmodule // move_arith_datapath_test
`default_nettype wire
